// ==== design/ssq_top.sv ====
// Purpose: Startup, pairing and normal-mode sequencer of a safety switch
// Assumes: Paired codes kept in an external nonvolatile store
// Notes: Contract
// Contract
// RULE_01: After supply, about 5 s self-test with lamp blinking green at 5 Hz.
// RULE_02: Open-coding variant enters normal mode straight after self-test.
// RULE_03: Both safety outputs stay off throughout pairing.
// RULE_04: Pairing is allowed only with no fault present.
// RULE_05: Learn window unlimited when never paired, about 3 min on re-pairing.
// RULE_06: Ready to learn shows two green blinks then long off.
// RULE_07: Actuator arriving starts pairing, lamp short off, long green.
// RULE_08: Pairing succeeds only after about 30 s continuous presence.
// RULE_09: Permanent variant pairs exactly once, refuses any further actuator.
// RULE_10: Rewritable variant pairs repeatedly, only last paired actuator valid.
// RULE_11: New pairing stores previous code as blocked, refused next time.
// RULE_12: Further pairing unblocks older code, blocks replaced one, one blocked only.
// RULE_13: Actuator leaving before 30 s is rejected, old pairing kept.
// RULE_14: Success shows short red alternating with long green.
// RULE_15: Failure, blocked actuator included, shows long red with short green.
// RULE_16: Supply must be cycled after pairing, normal mode after self-test.
// RULE_17: Normal mode with guard open shows short green, long off.
// RULE_18: Automatic start goes straight to closed, lamp steady green.
// RULE_19: Manual start waits after closing, lamp blinking at 1 Hz.
// RULE_20: Start accepted only on button press then release, then steady green.
// RULE_21: Rewritable variant with open guard at power-up goes ready to learn.
// RULE_22: Waiting for start keeps safety outputs off, signal output on.
// RULE_23: All durations come from clock-derived counters, pattern lengths parameters.
// RULE_24: Paired code, blocked code and paired flag live in nonvolatile storage.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.

`timescale 1ns/1ps

module ssq_top #(
   parameter int CODE_W = 16,
   parameter int MS_CYCLES = ssq_pkg::MS_CYCLES,
   parameter int SELFTEST_MS = ssq_pkg::SELFTEST_MS,
   parameter int LEARN_MS = ssq_pkg::LEARN_MS,
   parameter int READY_MS = ssq_pkg::READY_MS,
   parameter int SHORT_MS = ssq_pkg::SHORT_MS,
   parameter int LONG_MS = ssq_pkg::LONG_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic actuator_present,
   input wire logic [CODE_W-1:0] actuator_code,
   input wire logic reset_button,
   input wire logic fault_in,
   input wire logic nv_paired,
   input wire logic [CODE_W-1:0] nv_code,
   input wire logic nv_blocked_valid,
   input wire logic [CODE_W-1:0] nv_blocked_code,
   output logic nv_we,
   output logic [CODE_W-1:0] nv_wr_code,
   output logic nv_wr_blocked_valid,
   output logic [CODE_W-1:0] nv_wr_blocked_code,
   output logic state_lamp,
   output logic fault_lamp,
   output logic safety_out_a,
   output logic safety_out_b,
   output logic signal_output
);
   import ssq_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      ssq_state_e st;
      logic [16:0] tick;
      logic [17:0] ms;
      logic [11:0] pat;
      logic [2:0] act_sync;
      logic act_deb;
      logic [2:0] btn_sync;
      logic btn_deb;
      logic btn_armed;
      logic limited;
      logic paired;
      logic [CODE_W-1:0] code;
      logic blk_valid;
      logic [CODE_W-1:0] blk_code;
      logic [CODE_W-1:0] cand;
      logic [2:0] ctrl;
      logic nv_we;
      logic [CODE_W-1:0] nv_code;
      logic nv_blk_valid;
      logic [CODE_W-1:0] nv_blk_code;
      logic state_lamp;
      logic fault_lamp;
      logic safe_on;
      logic signal_on;
      logic aw_got;
      logic w_got;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ssq_regs_s;

   ssq_regs_s s_r;
   ssq_regs_s s_nxt;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [11:0] pat_period(input ssq_state_e st);
      case (st)
         ST_SELFTEST: pat_period = 12'(FAST_PERIOD_MS);
         ST_WAIT: pat_period = 12'(SLOW_PERIOD_MS);
         ST_READY: pat_period = 12'(4 * SHORT_MS + LONG_MS);
         default: pat_period = 12'(SHORT_MS + LONG_MS);
      endcase
   endfunction

   function automatic logic in_win(input logic [11:0] ph, input int lo, input int hi);
      in_win = (ph >= 12'(lo)) && (ph < 12'(hi));
   endfunction

   logic ms_pulse;
   logic guard;
   logic [1:0] variant;
   logic manual;
   ssq_state_e go;
   logic [31:0] rd_val;
   logic rd_ok;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      s_nxt = s_r;
      variant = s_r.ctrl[CTRL_VARIANT_LSB +: 2];
      manual = s_r.ctrl[CTRL_MANUAL_BIT];
      go = s_r.st;
      rd_val = 32'h0;
      rd_ok = 1'b1;
      s_nxt.nv_we = 1'b0;

      // Input synchronisers, change taken once last two stages agree
      s_nxt.act_sync = {s_r.act_sync[1:0], actuator_present};
      s_nxt.btn_sync = {s_r.btn_sync[1:0], reset_button};
      if (s_r.act_sync[1] == s_r.act_sync[2]) begin
         s_nxt.act_deb = s_r.act_sync[2];
      end
      if (s_r.btn_sync[1] == s_r.btn_sync[2]) begin
         s_nxt.btn_deb = s_r.btn_sync[2];
      end

      // Millisecond base
      ms_pulse = (s_r.tick == 17'(MS_CYCLES - 1)); // see RULE_23
      s_nxt.tick = ms_pulse ? 17'h0 : s_r.tick + 17'h1;
      if (ms_pulse && (s_r.ms != 18'h3ffff)) begin
         s_nxt.ms = s_r.ms + 18'h1;
      end
      if (ms_pulse) begin
         s_nxt.pat = (s_r.pat + 12'h1 >= pat_period(s_r.st)) ? 12'h0 : s_r.pat + 12'h1;
      end

      guard = s_r.act_deb && ((variant == VAR_OPEN) || (actuator_code == s_r.code));

      case (s_r.st)
         ST_SELFTEST: begin
            s_nxt.paired = nv_paired; // see RULE_24
            s_nxt.code = nv_code;
            s_nxt.blk_valid = nv_blocked_valid;
            s_nxt.blk_code = nv_blocked_code;
            if (s_r.ms >= 18'(SELFTEST_MS)) begin // see RULE_01
               if (variant == VAR_OPEN) begin
                  go = guard ? (manual ? ST_WAIT : ST_CLOSED) : ST_OPEN; // see RULE_02
               end else if (!s_r.paired || ((variant == VAR_REWRITE) && !s_r.act_deb)) begin // see RULE_09
                  go = ST_READY; // see RULE_21
               end else begin
                  go = guard ? (manual ? ST_WAIT : ST_CLOSED) : ST_OPEN; // see RULE_16
               end
               s_nxt.limited = s_r.paired; // see RULE_05
            end
         end
         ST_READY: begin
            if (s_r.limited && (s_r.ms >= 18'(READY_MS))) begin // see RULE_05
               go = ST_OPEN;
            end else if (s_r.act_deb) begin
               s_nxt.cand = actuator_code;
               if ((variant == VAR_REWRITE) && s_r.blk_valid && (actuator_code == s_r.blk_code)) begin
                  go = ST_FAIL; // see RULE_11
               end else begin
                  go = ST_LEARN; // see RULE_07
               end
            end
         end
         ST_LEARN: begin
            if (!s_r.act_deb || (actuator_code != s_r.cand)) begin
               go = ST_FAIL; // see RULE_13
            end else if (s_r.ms >= 18'(LEARN_MS)) begin // see RULE_08
               go = ST_OK;
               s_nxt.nv_we = 1'b1; // see RULE_24
               s_nxt.nv_code = s_r.cand; // see RULE_10
               s_nxt.nv_blk_valid = s_r.paired && (variant == VAR_REWRITE); // see RULE_12
               s_nxt.nv_blk_code = s_r.code; // see RULE_11
            end
         end
         ST_OPEN: begin
            if (guard) begin
               go = manual ? ST_WAIT : ST_CLOSED; // see RULE_18
            end
         end
         ST_WAIT: begin
            if (!guard) begin
               go = ST_OPEN;
            end else if (s_r.btn_deb && !s_nxt.btn_deb && s_r.btn_armed) begin
               go = ST_CLOSED; // see RULE_20
            end else if (!s_r.btn_deb && s_nxt.btn_deb) begin
               s_nxt.btn_armed = 1'b1;
            end
         end
         ST_CLOSED: begin
            if (!guard) begin
               go = ST_OPEN;
            end
         end
         default: begin
            go = s_r.st; // see RULE_16
         end
      endcase

      if (fault_in && (s_r.st != ST_FAULT)) begin
         go = ST_FAULT; // see RULE_04
      end
      if (go != s_r.st) begin
         s_nxt.st = go;
         s_nxt.ms = 18'h0;
         s_nxt.pat = 12'h0;
         s_nxt.btn_armed = 1'b0;
      end

      // Lamps and outputs
      s_nxt.fault_lamp = 1'b0;
      s_nxt.state_lamp = 1'b0;
      case (go)
         ST_SELFTEST: s_nxt.state_lamp = in_win(s_nxt.pat, 0, FAST_PERIOD_MS / 2); // see RULE_01
         ST_OPEN: s_nxt.state_lamp = in_win(s_nxt.pat, 0, SHORT_MS); // see RULE_17
         ST_WAIT: s_nxt.state_lamp = in_win(s_nxt.pat, 0, SLOW_PERIOD_MS / 2); // see RULE_19
         ST_CLOSED: s_nxt.state_lamp = 1'b1; // see RULE_18
         ST_READY: begin
            s_nxt.state_lamp = in_win(s_nxt.pat, 0, SHORT_MS)
               || in_win(s_nxt.pat, 2 * SHORT_MS, 3 * SHORT_MS); // see RULE_06
         end
         ST_LEARN: s_nxt.state_lamp = !in_win(s_nxt.pat, 0, SHORT_MS); // see RULE_07
         ST_OK: begin
            s_nxt.fault_lamp = in_win(s_nxt.pat, 0, SHORT_MS); // see RULE_14
            s_nxt.state_lamp = !in_win(s_nxt.pat, 0, SHORT_MS);
         end
         ST_FAIL: begin
            s_nxt.fault_lamp = in_win(s_nxt.pat, 0, LONG_MS); // see RULE_15
            s_nxt.state_lamp = !in_win(s_nxt.pat, 0, LONG_MS);
         end
         default: s_nxt.fault_lamp = 1'b1;
      endcase
      s_nxt.safe_on = (go == ST_CLOSED); // see RULE_03
      s_nxt.signal_on = (go == ST_OPEN) || (go == ST_WAIT) || (go == ST_READY) || (go == ST_LEARN)
         || (go == ST_OK) || (go == ST_FAIL); // see RULE_22

      // ************************************************************
      // AXI4-Lite write
      // ************************************************************
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.waddr = s_axi_awaddr;
         s_nxt.awready = 1'b0;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
         s_nxt.wready = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         if (s_r.waddr == CTRL_ADDR) begin
            if (s_r.wstrb[0]) begin
               s_nxt.ctrl = s_r.wdata[2:0];
            end
         end else if ((s_r.waddr == STATUS_ADDR) || (s_r.waddr == CODE_ADDR) || (s_r.waddr == BLOCKED_ADDR)) begin
            s_nxt.bresp = RESP_OKAY;
         end else begin
            s_nxt.bresp = RESP_SLVERR;
         end
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end

      // ************************************************************
      // AXI4-Lite read
      // ************************************************************
      if (s_axi_araddr == CTRL_ADDR) begin
         rd_val = {29'h0, s_r.ctrl};
      end else if (s_axi_araddr == STATUS_ADDR) begin
         rd_val = {16'h0, s_r.blk_valid, s_r.paired, s_r.safe_on, s_r.signal_on, 3'h0, 9'(s_r.st)};
      end else if (s_axi_araddr == CODE_ADDR) begin
         rd_val = 32'(s_r.code);
      end else if (s_axi_araddr == BLOCKED_ADDR) begin
         rd_val = 32'(s_r.blk_code);
      end else begin
         rd_ok = 1'b0;
      end
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.arready = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rd_val;
         s_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.st <= ST_SELFTEST;
         s_r.ctrl <= CTRL_RESET;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign nv_we = s_r.nv_we;
   assign nv_wr_code = s_r.nv_code;
   assign nv_wr_blocked_valid = s_r.nv_blk_valid;
   assign nv_wr_blocked_code = s_r.nv_blk_code;
   assign state_lamp = s_r.state_lamp;
   assign fault_lamp = s_r.fault_lamp;
   assign safety_out_a = s_r.safe_on; // see RULE_03
   assign safety_out_b = s_r.safe_on; // see RULE_22
   assign signal_output = s_r.signal_on;

endmodule

// ==== design/ssq_pkg.sv ====
// Purpose: Shared constants and types of the safety switch sequencer
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes: Times are kept in their own unit, cycle counts derived from them

package ssq_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int CLK_HZ = 125000000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int SELFTEST_S = 5;
   localparam int LEARN_S = 30;
   localparam int READY_MIN = 3;
   localparam int SELFTEST_MS = SELFTEST_S * MS_PER_S;
   localparam int LEARN_MS = LEARN_S * MS_PER_S;
   localparam int READY_MS = READY_MIN * 60 * MS_PER_S;
   localparam int FAST_HZ = 5;
   localparam int SLOW_HZ = 1;
   localparam int FAST_PERIOD_MS = MS_PER_S / FAST_HZ;
   localparam int SLOW_PERIOD_MS = MS_PER_S / SLOW_HZ;
   localparam int SHORT_MS = 200;
   localparam int LONG_MS = 1000;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] CODE_ADDR = 8'h08;
   localparam logic [7:0] BLOCKED_ADDR = 8'h0c;
   localparam int CTRL_VARIANT_LSB = 0;
   localparam int CTRL_MANUAL_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // Coding variants and states
   // ************************************************************
   localparam logic [1:0] VAR_OPEN = 2'h0;
   localparam logic [1:0] VAR_ONCE = 2'h1;
   localparam logic [1:0] VAR_REWRITE = 2'h2;

   typedef enum logic [8:0] {
      ST_SELFTEST = 9'h001,
      ST_OPEN = 9'h002,
      ST_WAIT = 9'h004,
      ST_CLOSED = 9'h008,
      ST_READY = 9'h010,
      ST_LEARN = 9'h020,
      ST_OK = 9'h040,
      ST_FAIL = 9'h080,
      ST_FAULT = 9'h100
   } ssq_state_e;

endpackage

// ==== sim/ssq_nv_model.sv ====
// Purpose: Nonvolatile pairing store
// Assumes: Written by the one-cycle store pulse
// Notes: No reset, contents outlive a supply cycle
`timescale 1ns/1ps
module ssq_nv_model #(
   parameter int CODE_W = 16
) (
   input wire logic aclk,
   input wire logic nv_we,
   input wire logic [CODE_W-1:0] nv_wr_code,
   input wire logic nv_wr_blocked_valid,
   input wire logic [CODE_W-1:0] nv_wr_blocked_code,
   output logic nv_paired,
   output logic [CODE_W-1:0] nv_code,
   output logic nv_blocked_valid,
   output logic [CODE_W-1:0] nv_blocked_code
);
   // ****************************************
   // Storage cells
   // ****************************************
   initial begin
      nv_paired = 1'b0;
      nv_code = '0;
      nv_blocked_valid = 1'b0;
      nv_blocked_code = '0;
   end
   always @(posedge aclk) begin
      if (nv_we) begin
         nv_paired <= 1'b1;
         nv_code <= nv_wr_code;
         nv_blocked_valid <= nv_wr_blocked_valid;
         nv_blocked_code <= nv_wr_blocked_code;
      end
   end
endmodule

// ==== sim/ssq_properties.sv ====
// Purpose: Port checks of the sequencer
// Assumes: Shortened timing handed on by bind
// Notes: Watches design inputs and outputs only
`timescale 1ns/1ps
module ssq_properties #(
   parameter int CODE_W = 16,
   parameter int MS_CYCLES = 10,
   parameter int SELFTEST_MS = 5,
   parameter int LEARN_MS = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic actuator_present,
   input wire logic [CODE_W-1:0] actuator_code,
   input wire logic fault_in,
   input wire logic nv_paired,
   input wire logic [CODE_W-1:0] nv_code,
   input wire logic nv_we,
   input wire logic [CODE_W-1:0] nv_wr_code,
   input wire logic nv_wr_blocked_valid,
   input wire logic [CODE_W-1:0] nv_wr_blocked_code,
   input wire logic state_lamp,
   input wire logic fault_lamp,
   input wire logic safety_out_a,
   input wire logic safety_out_b,
   input wire logic signal_output
);
   // ****************************************
   // Presence and uptime counters
   // ****************************************
   logic [31:0] run_r;
   logic [31:0] up_r;
   always_ff @(posedge aclk) begin
      run_r <= !actuator_present ? 32'h0 : run_r + {31'h0, run_r < 32'h0fffffff};
      up_r <= !aresetn ? 32'h0 : up_r + {31'h0, up_r < 32'h0fffffff};
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****************************************
   // Assertions
   // ****************************************
   quiet_selftest_a: assert property (up_r < 32'(SELFTEST_MS * MS_CYCLES)
      |-> !signal_output && !safety_out_a && !fault_lamp) else $error("output active in self-test");
   pair_outs_off_a: assert property (nv_we |-> !safety_out_a && !safety_out_b)
      else $error("safety output on while pairing");
   fault_safe_a: assert property (fault_in |-> ##3 (fault_lamp && !safety_out_a && !safety_out_b))
      else $error("fault did not force safe state");
   learn_time_a: assert property (nv_we |-> run_r >= 32'(LEARN_MS * MS_CYCLES))
      else $error("pairing stored too early");
   code_stored_a: assert property (nv_we |-> nv_wr_code == actuator_code)
      else $error("stored code is not the present one");
   block_prev_a: assert property (nv_we && nv_paired
      |-> nv_wr_blocked_valid && nv_wr_blocked_code == nv_code) else $error("previous code not blocked");
   block_none_a: assert property (nv_we && !nv_paired |-> !nv_wr_blocked_valid)
      else $error("blocked code on first pairing");
   one_write_a: assert property (nv_we |=> !nv_we [*8])
      else $error("repeated pairing write");
   closed_green_a: assert property (safety_out_a |-> state_lamp && !fault_lamp && safety_out_b)
      else $error("closed state lamps wrong");
   wait_outs_a: assert property (signal_output |-> !safety_out_a && !safety_out_b)
      else $error("safety output on with signal output");
endmodule

bind ssq_top ssq_properties #(.CODE_W(CODE_W), .MS_CYCLES(MS_CYCLES), .SELFTEST_MS(SELFTEST_MS), .LEARN_MS(LEARN_MS))
   ssq_properties_inst (.aclk, .aresetn, .actuator_present, .actuator_code, .fault_in, .nv_paired, .nv_code,
   .nv_we, .nv_wr_code, .nv_wr_blocked_valid, .nv_wr_blocked_code, .state_lamp, .fault_lamp, .safety_out_a,
   .safety_out_b, .signal_output);

// ==== sim/ssq_top_bench.sv ====
// Purpose: Self-checking bench of the sequencer
// Assumes: Shortened timing, store model outlives resets
// Notes: Register rows first, then sequences
`timescale 1ns/1ps
module ssq_top_bench;
   import ssq_pkg::*;
   localparam int LIMIT = 70000;
   typedef struct packed {
      logic [7:0] addr;
      logic [1:0] resp;
      logic [31:0] data;
   } ssq_row_s;
   ssq_row_s rows [4] = '{'{CTRL_ADDR, RESP_OKAY, 32'h0}, '{STATUS_ADDR, RESP_OKAY, 32'h1},
      '{8'h10, RESP_SLVERR, 32'h0}, '{8'h40, RESP_SLVERR, 32'h0}};
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, actuator_present = 1'b0, reset_button = 1'b0, fault_in = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [15:0] actuator_code = 16'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nv_paired, nv_blocked_valid;
   logic nv_we, nv_wr_blocked_valid, state_lamp, fault_lamp, safety_out_a, safety_out_b, signal_output;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] nv_code, nv_blocked_code, nv_wr_code, nv_wr_blocked_code;
   int errors = 0, checks_done = 0, cyc = 0;
   ssq_top #(.MS_CYCLES(1), .LEARN_MS(200), .READY_MS(300), .SHORT_MS(2), .LONG_MS(5))
      ssq_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .actuator_present, .actuator_code,
      .reset_button, .fault_in, .nv_paired, .nv_code, .nv_blocked_valid, .nv_blocked_code, .nv_we, .nv_wr_code,
      .nv_wr_blocked_valid, .nv_wr_blocked_code, .state_lamp, .fault_lamp, .safety_out_a, .safety_out_b,
      .signal_output);
   ssq_nv_model ssq_nv_model_inst (.aclk, .nv_we, .nv_wr_code, .nv_wr_blocked_valid,
      .nv_wr_blocked_code, .nv_paired, .nv_code, .nv_blocked_valid, .nv_blocked_code);
   always #4 aclk = ~aclk;
   // ****************************************
   // Tasks
   // ****************************************
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
      logic aw_done = 1'b0;
      logic w_done = 1'b0;
      s_axi_awaddr <= addr;
      s_axi_wdata <= data;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] addr, output logic [31:0] rd, output logic [1:0] resp);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic st(input logic [8:0] exp);
      logic [31:0] rd;
      logic [1:0] resp;
      axi_read(STATUS_ADDR, rd, resp);
      check({23'h0, rd[8:0]}, {23'h0, exp});
   endtask
   task automatic duty(input int n, output int on_g, output int on_r);
      on_g = 0;
      on_r = 0;
      repeat (n) begin
         @(posedge aclk);
         on_g += int'(state_lamp === 1'b1);
         on_r += int'(fault_lamp === 1'b1);
      end
   endtask
   task automatic power(input logic [2:0] ctrl, input logic pres, input logic [15:0] code);
      logic [1:0] resp;
      aresetn <= 1'b0;
      actuator_present <= pres;
      actuator_code <= code;
      cycles(10);
      aresetn <= 1'b1;
      cycles(1);
      axi_write(CTRL_ADDR, {29'h0, ctrl}, resp);
      check({30'h0, resp}, {30'h0, RESP_OKAY});
      cycles(5075);
   endtask
   task automatic pair(input logic [15:0] code, input logic bv, input logic [15:0] bc);
      power(3'h2, 1'b0, code);
      actuator_present <= 1'b1;
      cycles(250);
      st(9'h040);
      check({15'h0, nv_wr_blocked_valid, nv_wr_code}, {15'h0, bv, code});
      check({16'h0, bv ? nv_wr_blocked_code : 16'h0}, {16'h0, bc});
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] rd;
      logic [1:0] resp;
      int on_g;
      int on_r;
      cycles(10);
      aresetn <= 1'b1;
      cycles(1);
      foreach (rows[i]) begin
         axi_read(rows[i].addr, rd, resp);
         check({resp, rd[29:0]}, {rows[i].resp, rows[i].data[29:0]});
      end
      cycles(5075);
      st(9'h002);
      duty(140, on_g, on_r);
      check({31'h0, on_g < 70 && on_g > 0}, 32'h1);
      actuator_present <= 1'b1;
      actuator_code <= 16'h1111;
      cycles(10);
      st(9'h008);
      fault_in <= 1'b1;
      cycles(5);
      fault_in <= 1'b0;
      st(9'h100);
      power(3'h4, 1'b1, 16'h1111);
      st(9'h004);
      check({30'h0, safety_out_a, signal_output}, 32'h1);
      reset_button <= 1'b1;
      cycles(10);
      st(9'h004);
      reset_button <= 1'b0;
      cycles(10);
      st(9'h008);
      power(3'h2, 1'b0, 16'h1111);
      st(9'h010);
      duty(140, on_g, on_r);
      check({31'h0, on_g < 70 && on_g > 0}, 32'h1);
      cycles(400);
      st(9'h010);
      actuator_present <= 1'b1;
      cycles(10);
      st(9'h020);
      duty(60, on_g, on_r);
      check({31'h0, on_g > 30 && safety_out_a === 1'b0}, 32'h1);
      actuator_present <= 1'b0;
      cycles(10);
      st(9'h080);
      duty(140, on_g, on_r);
      check({31'h0, on_r > 70 && on_g > 0}, 32'h1);
      check({31'h0, nv_paired}, 32'h0);
      pair(16'h1111, 1'b0, 16'h0);
      duty(140, on_g, on_r);
      check({31'h0, on_g > 70 && on_r > 0 && on_r < 70}, 32'h1);
      power(3'h2, 1'b0, 16'h1111);
      cycles(330);
      st(9'h002);
      pair(16'h2222, 1'b1, 16'h1111);
      power(3'h2, 1'b0, 16'h1111);
      actuator_present <= 1'b1;
      cycles(20);
      st(9'h080);
      pair(16'h3333, 1'b1, 16'h2222);
      power(3'h2, 1'b1, 16'h3333);
      st(9'h008);
      power(3'h2, 1'b1, 16'h2222);
      check({31'h0, safety_out_a}, 32'h0);
      power(3'h1, 1'b0, 16'h1111);
      st(9'h002);
      report_and_stop();
   end
endmodule
